// ### fspc_host.sv
// Function
// RL1: protect needs high voltage held on A9 and output enable pins.
// RL2: device refuses program and erase inside a protected sector.
// RL3: protect bit set runs from write-enable falling to rising edge.
// RL4: verify holds A9 high voltage, chip and output enable low, write high.
// RL5: verify with A1 high, A0 and A6 low gives bit0 one if protected.
// RL6: in verify mode the sector address on A19-A16 selects which sector is reported.
// RL7: reads with A1 low in identification mode return identity codes.
// RL8: in-system identification command then A1-high read shows protect bit.
// RL9: host writes reset command to leave identification read mode.
// RL10: unprotect holds high voltage on output enable and A9, chip low, A6 high.
// RL11: chip unprotect runs from write-enable falling to rising edge.
// RL12: completed unprotect clears every sector's protect state together.
// RL13: protecting all sectors before chip unprotect is recommended; the host does not, and the bench protects only SEC_A and SEC_B first.
// RL14: after unprotect, A1-high identification read gives all-zero byte.
// RL15: reset pin at high voltage lifts protection until removed.
// RL16: high voltage on A9, output enable and reset are separate qualifiers.
`timescale 1ns/1ps

`include "fspc_cfg.svh"

module fspc_host #(
   parameter int unsigned            UNPROT_PULSE_CYC = `FSPC_WPP2_CYC,
   parameter logic [`FSPC_ADDR_W-1:0] ID_CMD_ADDR     = 20'h00001,
   parameter logic [`FSPC_DATA_W-1:0] ID_CMD_DATA     = 8'h01,
   parameter logic [`FSPC_DATA_W-1:0] RST_CMD_DATA    = 8'h02
) (
   // Clock, reset, enable
   input  wire logic                    clk,
   input  wire logic                    rstn,
   input  wire logic                    clk_en,
   // Request side
   input  wire logic                    req_valid,
   output logic                         req_ready,
   input  wire fspc_pkg::fspc_req_s     req,
   input  wire logic                    temp_unprot,
   // Answer side
   output logic                         rsp_valid,
   output fspc_pkg::fspc_rsp_s          rsp,
   // Flash pins
   output fspc_pkg::fspc_pins_s         flash,
   input  wire logic [`FSPC_DATA_W-1:0] dq_in
);

   fspc_pkg::fspc_state_e state;
   fspc_pkg::fspc_state_e next_state;
   fspc_pkg::fspc_op_e    op;
   logic [`FSPC_ADDR_W-1:0] addr;
   logic [31:0]           cnt;
   logic                  last;
   fspc_pkg::fspc_pins_s  next_pins;

   function automatic logic [31:0] dur(input fspc_pkg::fspc_state_e st, input fspc_pkg::fspc_op_e o);
      case (st)
         fspc_pkg::FSPC_ST_RAMP:    dur = `FSPC_VLHT_CYC;
         fspc_pkg::FSPC_ST_RELEASE: dur = `FSPC_VLHT_CYC;
         fspc_pkg::FSPC_ST_OESP:    dur = `FSPC_OESP_CYC;
         fspc_pkg::FSPC_ST_PULSE:   dur = (o == fspc_pkg::FSPC_OP_PROTECT) ? `FSPC_WPP1_CYC : UNPROT_PULSE_CYC;
         fspc_pkg::FSPC_ST_READ:    dur = `FSPC_ACC_CYC;
         fspc_pkg::FSPC_ST_ID_LO:   dur = `FSPC_WP_CYC;
         fspc_pkg::FSPC_ST_RST_LO:  dur = `FSPC_WP_CYC;
         fspc_pkg::FSPC_ST_ID_HI:   dur = `FSPC_WPH_CYC;
         fspc_pkg::FSPC_ST_RST_HI:  dur = `FSPC_WPH_CYC;
         default:                   dur = 32'h00000001;
      endcase
   endfunction

   assign req_ready = (state == fspc_pkg::FSPC_ST_IDLE);
   assign last      = (cnt == dur(state, op) - 32'h00000001);

   always_comb begin
      next_state = state;
      case (state)
         fspc_pkg::FSPC_ST_IDLE: begin
            if (req_valid) begin
               next_state = (req.op == fspc_pkg::FSPC_OP_ID_CHECK) ? fspc_pkg::FSPC_ST_ID_LO : fspc_pkg::FSPC_ST_RAMP;
            end
         end
         fspc_pkg::FSPC_ST_RAMP: begin
            if (last) begin
               next_state = (op == fspc_pkg::FSPC_OP_VERIFY) ? fspc_pkg::FSPC_ST_READ : fspc_pkg::FSPC_ST_OESP;
            end
         end
         fspc_pkg::FSPC_ST_OESP:    if (last) next_state = fspc_pkg::FSPC_ST_PULSE;
         fspc_pkg::FSPC_ST_PULSE:   if (last) next_state = fspc_pkg::FSPC_ST_RELEASE;
         fspc_pkg::FSPC_ST_RELEASE: if (last) next_state = fspc_pkg::FSPC_ST_DONE;
         fspc_pkg::FSPC_ST_READ: begin
            if (last) begin
               // Identification mode must be left by the reset command
               next_state = (op == fspc_pkg::FSPC_OP_VERIFY) ? fspc_pkg::FSPC_ST_RELEASE
                                                              : fspc_pkg::FSPC_ST_RST_LO; // RL9
            end
         end
         fspc_pkg::FSPC_ST_ID_LO:   if (last) next_state = fspc_pkg::FSPC_ST_ID_HI;
         fspc_pkg::FSPC_ST_ID_HI:   if (last) next_state = fspc_pkg::FSPC_ST_READ;
         fspc_pkg::FSPC_ST_RST_LO:  if (last) next_state = fspc_pkg::FSPC_ST_RST_HI;
         fspc_pkg::FSPC_ST_RST_HI:  if (last) next_state = fspc_pkg::FSPC_ST_DONE;
         fspc_pkg::FSPC_ST_DONE:    next_state = fspc_pkg::FSPC_ST_IDLE;
         default:                   next_state = fspc_pkg::FSPC_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state <= fspc_pkg::FSPC_ST_IDLE;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         cnt <= 32'h00000000;
      end else if (clk_en) begin
         cnt <= (state != next_state) ? 32'h00000000 : cnt + 32'h00000001;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         op   <= fspc_pkg::FSPC_OP_PROTECT;
         addr <= 20'h00000;
      end else if (clk_en && req_valid && req_ready) begin
         op   <= req.op;
         addr <= req.addr;
      end
   end

   // Pins follow the next state so they line up with the state register
   always_comb begin
      fspc_pkg::fspc_op_e      o;
      logic [`FSPC_ADDR_W-1:0] a;
      o = (state == fspc_pkg::FSPC_ST_IDLE) ? req.op : op;
      a = (state == fspc_pkg::FSPC_ST_IDLE) ? req.addr : addr;
      next_pins           = '0;
      next_pins.chip_en_n = 1'b1;
      next_pins.out_en_n  = 1'b1;
      next_pins.wr_en_n   = 1'b1;
      next_pins.hv_reset  = temp_unprot; // RL15 RL16
      case (next_state)
         fspc_pkg::FSPC_ST_RAMP, fspc_pkg::FSPC_ST_OESP, fspc_pkg::FSPC_ST_PULSE: begin
            next_pins.chip_en_n = 1'b0;
            next_pins.hv_a9     = 1'b1; // RL1 RL16
            next_pins.hv_oe     = (o != fspc_pkg::FSPC_OP_VERIFY); // RL1 RL10 RL16
            next_pins.addr      = a;
            next_pins.addr[`FSPC_A6_BIT] = (o == fspc_pkg::FSPC_OP_UNPROTECT); // RL10
            next_pins.addr[`FSPC_A1_BIT] = 1'b1;
            next_pins.addr[`FSPC_A0_BIT] = 1'b0;
            next_pins.wr_en_n   = (next_state != fspc_pkg::FSPC_ST_PULSE); // RL3 RL11
         end
         fspc_pkg::FSPC_ST_READ: begin
            next_pins.chip_en_n = 1'b0;
            next_pins.out_en_n  = 1'b0;
            next_pins.hv_a9     = (o == fspc_pkg::FSPC_OP_VERIFY); // RL4
            next_pins.addr      = a;
            // A1 high selects protect status, A1 low would give identity codes
            next_pins.addr[`FSPC_A1_BIT] = 1'b1; // RL5 RL7 RL8
            next_pins.addr[`FSPC_A0_BIT] = 1'b0; // RL5
            next_pins.addr[`FSPC_A6_BIT] = 1'b0; // RL5
         end
         fspc_pkg::FSPC_ST_ID_LO, fspc_pkg::FSPC_ST_RST_LO: begin
            next_pins.chip_en_n = 1'b0;
            next_pins.wr_en_n   = 1'b0;
            next_pins.addr      = ID_CMD_ADDR;
            next_pins.dq_oe     = 1'b1;
            next_pins.dq_out    = (next_state == fspc_pkg::FSPC_ST_ID_LO) ? ID_CMD_DATA : RST_CMD_DATA; // RL8 RL9
         end
         fspc_pkg::FSPC_ST_ID_HI, fspc_pkg::FSPC_ST_RST_HI: begin
            next_pins.addr      = ID_CMD_ADDR;
         end
         default: begin
            next_pins.hv_reset  = temp_unprot;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         flash <= '{addr: 20'h00000, chip_en_n: 1'b1, out_en_n: 1'b1, wr_en_n: 1'b1, hv_a9: 1'b0,
                    hv_oe: 1'b0, hv_reset: 1'b0, dq_out: 8'h00, dq_oe: 1'b0};
      end else if (clk_en) begin
         flash <= next_pins;
      end
   end

   // Status is taken on the last access cycle, after the full access time
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rsp <= '0;
      end else if (clk_en && state == fspc_pkg::FSPC_ST_READ && last) begin
         rsp.status   <= dq_in;
         rsp.prot     <= dq_in[0]; // RL5 RL8
         rsp.all_zero <= (dq_in == 8'h00); // RL14
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rsp_valid <= 1'b0;
      end else if (clk_en) begin
         rsp_valid <= (next_state == fspc_pkg::FSPC_ST_DONE);
      end
   end

   // Checks
   logic [31:0] we_low_cnt;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         we_low_cnt <= 32'h00000000;
      end else if (clk_en) begin
         we_low_cnt <= flash.wr_en_n ? 32'h00000000 : we_low_cnt + 32'h00000001;
      end
   end

   sequence s_we_rise;
      $rose(flash.wr_en_n) && clk_en;
   endsequence

   sequence s_id_read_end;
      state == fspc_pkg::FSPC_ST_READ && op == fspc_pkg::FSPC_OP_ID_CHECK && last && clk_en;
   endsequence

   sequence s_rst_write;
      !flash.wr_en_n && flash.dq_oe && flash.dq_out == RST_CMD_DATA;
   endsequence

   prot_pulse_len_a: assert property (@(posedge clk) disable iff (!rstn) // RL3
      s_we_rise ##0 (op == fspc_pkg::FSPC_OP_PROTECT && $past(flash.hv_oe)) |-> we_low_cnt == `FSPC_WPP1_CYC)
      else $error("protect pulse width wrong");

   unprot_pulse_len_a: assert property (@(posedge clk) disable iff (!rstn) // RL11
      s_we_rise ##0 (op == fspc_pkg::FSPC_OP_UNPROTECT) |-> we_low_cnt == UNPROT_PULSE_CYC)
      else $error("unprotect pulse width wrong");

   protect_pins_a: assert property (@(posedge clk) disable iff (!rstn) // RL1
      (!flash.wr_en_n && op == fspc_pkg::FSPC_OP_PROTECT && !flash.dq_oe)
      |-> flash.hv_a9 && flash.hv_oe && !flash.addr[`FSPC_A6_BIT])
      else $error("protect pulse without high voltage");

   unprot_pins_a: assert property (@(posedge clk) disable iff (!rstn) // RL10
      (!flash.wr_en_n && op == fspc_pkg::FSPC_OP_UNPROTECT)
      |-> flash.hv_a9 && flash.hv_oe && !flash.chip_en_n && flash.addr[`FSPC_A6_BIT])
      else $error("unprotect pins wrong");

   verify_pins_a: assert property (@(posedge clk) disable iff (!rstn) // RL4
      (!flash.out_en_n && flash.hv_a9)
      |-> !flash.chip_en_n && flash.wr_en_n && !flash.hv_oe && flash.addr[`FSPC_A1_BIT]
          && !flash.addr[`FSPC_A0_BIT] && !flash.addr[`FSPC_A6_BIT])
      else $error("verify pins wrong");

   id_reset_follows_a: assert property (@(posedge clk) disable iff (!rstn) // RL9
      s_id_read_end |=> s_rst_write)
      else $error("reset command missing after identification read");

   id_no_hv_a: assert property (@(posedge clk) disable iff (!rstn) // RL8
      (op == fspc_pkg::FSPC_OP_ID_CHECK && !flash.out_en_n)
      |-> !flash.hv_a9 && !flash.hv_oe && flash.addr[`FSPC_A1_BIT])
      else $error("in-system read misdriven");

   temp_unprot_a: assert property (@(posedge clk) disable iff (!rstn) // RL15
      clk_en |=> flash.hv_reset == $past(temp_unprot))
      else $error("reset high voltage does not follow request");

   release_hv_a: assert property (@(posedge clk) disable iff (!rstn)
      (rsp_valid) |-> !flash.hv_a9 && !flash.hv_oe && flash.wr_en_n)
      else $error("high voltage held at completion");

endmodule

// ### fspc_cfg.svh
`ifndef FSPC_CFG_SVH
`define FSPC_CFG_SVH

// Clock period and pin widths
`define FSPC_CLK_NS       32'h0000000A
`define FSPC_ADDR_W       20
`define FSPC_DATA_W       8

// Address bit positions used by the protect modes
`define FSPC_A0_BIT       0
`define FSPC_A1_BIT       1
`define FSPC_A6_BIT       6
`define FSPC_A9_BIT       9

// Times in ns: 4000, 4000, 10000, 12000000, 90, 35, 30
`define FSPC_T_VLHT_NS    32'h00000FA0
`define FSPC_T_OESP_NS    32'h00000FA0
`define FSPC_T_WPP1_NS    32'h00002710
`define FSPC_T_WPP2_NS    32'h00B71B00
`define FSPC_T_ACC_NS     32'h0000005A
`define FSPC_T_WP_NS      32'h00000023
`define FSPC_T_WPH_NS     32'h0000001E

// Least times round up to whole cycles
`define FSPC_CYC_UP(ns)   (((ns) + `FSPC_CLK_NS - 32'h00000001) / `FSPC_CLK_NS)
`define FSPC_VLHT_CYC     `FSPC_CYC_UP(`FSPC_T_VLHT_NS)
`define FSPC_OESP_CYC     `FSPC_CYC_UP(`FSPC_T_OESP_NS)
`define FSPC_WPP1_CYC     `FSPC_CYC_UP(`FSPC_T_WPP1_NS)
`define FSPC_WPP2_CYC     `FSPC_CYC_UP(`FSPC_T_WPP2_NS)
`define FSPC_ACC_CYC      `FSPC_CYC_UP(`FSPC_T_ACC_NS)
`define FSPC_WP_CYC       `FSPC_CYC_UP(`FSPC_T_WP_NS)
`define FSPC_WPH_CYC      `FSPC_CYC_UP(`FSPC_T_WPH_NS)

`endif

// ### fspc_pkg.sv
`include "fspc_cfg.svh"

package fspc_pkg;

   typedef enum logic [1:0] {
      FSPC_OP_PROTECT,
      FSPC_OP_UNPROTECT,
      FSPC_OP_VERIFY,
      FSPC_OP_ID_CHECK
   } fspc_op_e;

   typedef enum logic [3:0] {
      FSPC_ST_IDLE,
      FSPC_ST_RAMP,
      FSPC_ST_OESP,
      FSPC_ST_PULSE,
      FSPC_ST_RELEASE,
      FSPC_ST_READ,
      FSPC_ST_ID_LO,
      FSPC_ST_ID_HI,
      FSPC_ST_RST_LO,
      FSPC_ST_RST_HI,
      FSPC_ST_DONE
   } fspc_state_e;

   typedef struct packed {
      fspc_op_e                  op;
      logic [`FSPC_ADDR_W-1:0]   addr;
   } fspc_req_s;

   typedef struct packed {
      logic [`FSPC_DATA_W-1:0]   status;
      logic                      prot;
      logic                      all_zero;
   } fspc_rsp_s;

   typedef struct packed {
      logic [`FSPC_ADDR_W-1:0]   addr;
      logic                      chip_en_n;
      logic                      out_en_n;
      logic                      wr_en_n;
      logic                      hv_a9;
      logic                      hv_oe;
      logic                      hv_reset;
      logic [`FSPC_DATA_W-1:0]   dq_out;
      logic                      dq_oe;
   } fspc_pins_s;

endpackage

// ### fspc_flash_model.sv
`timescale 1ns/1ps

module fspc_flash_model #(
   parameter logic [7:0] ID_CMD_DATA  = 8'h01,
   parameter logic [7:0] RST_CMD_DATA = 8'h02,
   // Arbitrary value, stands in for any identity code
   parameter logic [7:0] ID_CODE      = 8'hA5
) (
   // Pins driven by the host
   input  wire fspc_pkg::fspc_pins_s flash,
   // Data pins back to the host
   output logic [7:0]                dq_in
);
   logic [15:0] prot    = 16'h0000;
   logic        id_mode = 1'b0;
   logic [7:0]  last    = 8'h00;
   logic [3:0]  sec;
   logic        sector_writable;
   logic        reading;
   logic [7:0]  rd_val;
   fspc_pkg::fspc_pins_s wr_pins;

   assign sec = flash.addr[19:16];
   // Program and erase gate of a sector
   assign sector_writable = !prot[sec] || flash.hv_reset;

   // Pins latched as the pulse opens; the host drops them together with the rising edge
   always @(negedge flash.wr_en_n) begin
      wr_pins = flash;
   end

   // Protect and unprotect both complete on the write-enable rising edge
   always @(posedge flash.wr_en_n) begin
      if (!wr_pins.chip_en_n && wr_pins.hv_a9 && wr_pins.hv_oe) begin
         if (wr_pins.addr[6]) begin
            prot <= 16'h0000;
         end else begin
            prot[wr_pins.addr[19:16]] <= 1'b1;
         end
      end else if (!wr_pins.chip_en_n && wr_pins.dq_oe) begin
         if (wr_pins.dq_out == ID_CMD_DATA) begin
            id_mode <= 1'b1;
         end else if (wr_pins.dq_out == RST_CMD_DATA) begin
            id_mode <= 1'b0;
         end
      end
   end

   assign reading = !flash.chip_en_n && !flash.out_en_n && flash.wr_en_n && !flash.dq_oe;
   always_comb begin
      if (!flash.addr[1] && (id_mode || flash.hv_a9)) begin
         rd_val = ID_CODE;
      end else if (id_mode || flash.hv_a9) begin
         rd_val = {7'h00, prot[sec]};
      end else begin
         rd_val = 8'h3C;
      end
   end

   // Released bus shows the inverse so a stale value never passes for data
   always @* begin
      if (reading) begin
         dq_in = rd_val;
         last  = rd_val;
      end else begin
         dq_in = ~last;
      end
   end
endmodule

// ### fspc_host_bench.sv
`timescale 1ns/1ps

`include "fspc_cfg.svh"

module fspc_host_bench;
   localparam int unsigned UNPROT = 50;
   localparam logic [19:0] SEC_A  = 20'h00FFF;
   localparam logic [19:0] SEC_B  = 20'h31234;
   logic                 clk = 1'b0;
   logic                 rstn, clk_en, req_valid, req_ready, temp_unprot, rsp_valid;
   fspc_pkg::fspc_req_s  req;
   fspc_pkg::fspc_rsp_s  rsp;
   fspc_pkg::fspc_pins_s flash;
   logic [7:0]           dq_in;
   int                   err_count = 0;
   int                   cmp_count = 0;
   int                   wl_cnt, hv_bad, lat;

   fspc_host #(.UNPROT_PULSE_CYC(UNPROT), .ID_CMD_DATA(8'h01), .RST_CMD_DATA(8'h02)) DUT (
      .clk(clk), .rstn(rstn), .clk_en(clk_en), .req_valid(req_valid), .req_ready(req_ready),
      .req(req), .temp_unprot(temp_unprot), .rsp_valid(rsp_valid), .rsp(rsp), .flash(flash), .dq_in(dq_in));
   fspc_flash_model #(.ID_CMD_DATA(8'h01), .RST_CMD_DATA(8'h02)) model (.flash(flash), .dq_in(dq_in));

   initial begin
      forever #5 clk = ~clk;
   end

   // Width of high-voltage write pulses and voltage held through them
   always @(posedge clk) begin
      if (flash.wr_en_n === 1'b0 && flash.dq_oe === 1'b0) begin
         wl_cnt++;
         if (flash.hv_a9 !== 1'b1 || flash.hv_oe !== 1'b1) hv_bad++;
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: %s got %h want %h", $time, msg, seen, exp);
      end
   endtask

   task automatic finish_test();
      if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // Latency counts edges after the take edge, frozen edges included
   task automatic run_op(input fspc_pkg::fspc_op_e op, input logic [19:0] addr, input int stall, input int exp);
      wl_cnt = 0;
      hv_bad = 0;
      @(posedge clk);
      req.op <= op;
      req.addr <= addr;
      req_valid <= 1'b1;
      @(posedge clk);
      req_valid <= 1'b0;
      lat = 0;
      while (lat < 20000) begin
         @(posedge clk);
         #1;
         lat++;
         if (lat == 1) check(req_ready, 1'b0, "busy ready");
         if (rsp_valid === 1'b1) break;
         if (lat == 5 && stall > 0) begin
            @(posedge clk);
            clk_en <= 1'b0;
            repeat (stall) @(posedge clk);
            clk_en <= 1'b1;
            #1;
            lat += stall + 1;
         end
      end
      check(lat, exp, "latency");
   endtask

   task automatic t_reset();
      check({flash.chip_en_n, flash.out_en_n, flash.wr_en_n}, 8'h07, "idle strobes");
      check({flash.hv_a9, flash.hv_oe, flash.dq_oe, rsp_valid}, 8'h00, "idle hv");
      check(req_ready, 1'b1, "idle ready");
   endtask

   task automatic t_verify(input logic [19:0] addr, input logic p, input int stall);
      run_op(fspc_pkg::FSPC_OP_VERIFY, addr, stall, 2 * `FSPC_VLHT_CYC + `FSPC_ACC_CYC + stall);
      check(rsp.status, {7'h00, p}, "verify byte");
      check({rsp.prot, rsp.all_zero}, {p, !p}, "verify flags");
   endtask

   task automatic t_id(input logic [19:0] addr, input logic p);
      run_op(fspc_pkg::FSPC_OP_ID_CHECK, addr, 0, 2 * `FSPC_WP_CYC + 2 * `FSPC_WPH_CYC + `FSPC_ACC_CYC);
      check(rsp.status, {7'h00, p}, "id byte");
      check(model.id_mode, 1'b0, "id mode left");
   endtask

   task automatic t_protect(input logic [19:0] addr);
      run_op(fspc_pkg::FSPC_OP_PROTECT, addr, 0, 2 * `FSPC_VLHT_CYC + `FSPC_OESP_CYC + `FSPC_WPP1_CYC);
      check(wl_cnt, `FSPC_WPP1_CYC, "protect pulse");
      check(hv_bad, 8'h00, "protect hv");
   endtask

   task automatic t_unprotect();
      run_op(fspc_pkg::FSPC_OP_UNPROTECT, SEC_B, 0, 2 * `FSPC_VLHT_CYC + `FSPC_OESP_CYC + UNPROT);
      check(wl_cnt, UNPROT, "unprotect pulse");
      check(hv_bad, 8'h00, "unprotect hv");
   endtask

   task automatic t_temp();
      check(model.sector_writable, 1'b0, "locked sector");
      @(posedge clk);
      temp_unprot <= 1'b1;
      @(posedge clk);
      #1;
      check(flash.hv_reset, 1'b1, "hv reset on");
      check(model.sector_writable, 1'b1, "temp unlocked");
      @(posedge clk);
      temp_unprot <= 1'b0;
      @(posedge clk);
      #1;
      check({flash.hv_reset, model.sector_writable}, 8'h00, "relocked");
   endtask

   initial begin
      rstn = 1'b0;
      clk_en = 1'b1;
      req_valid = 1'b0;
      req = '0;
      temp_unprot = 1'b0;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      #1;
      t_reset();
      t_verify(SEC_A, 1'b0, 0);
      t_id(SEC_A, 1'b0);
      t_protect(SEC_A);
      t_verify(SEC_A, 1'b1, 30);
      t_verify(SEC_B, 1'b0, 0);
      t_id(SEC_A, 1'b1);
      t_id(SEC_B, 1'b0);
      t_temp();
      t_protect(SEC_B);
      t_unprotect();
      t_verify(SEC_A, 1'b0, 0);
      t_id(SEC_A, 1'b0);
      t_id(SEC_B, 1'b0);
      finish_test();
   end

   initial begin
      #500000;
      err_count++;
      finish_test();
   end
endmodule
